// File: logic/ccmc_top.sv
`timescale 1ns/1ps
`include "ccmc_params.svh"
module ccmc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] req_mode,
  output logic [2:0] op_mode,
  input wire logic [2:0] tx_load,
  input wire logic [`CCMC_WORD_W-1:0] tx_load_data,
  input wire logic [2:0] tx_req,
  input wire logic [2:0] tx_abort,
  input wire logic [1:0] tx_prio [3],
  output logic [2:0] tx_pending,
  input wire logic [2:0] rts_pin_n,
  input wire logic rts_gpio_en,
  output logic [2:0] rts_gpio_in,
  output logic [1:0] rx_full_pin_n,
  input wire logic rxf_gpio_en,
  input wire logic [1:0] rxf_gpio_out,
  input wire logic [`CCMC_WORD_W-1:0] filt_val [6],
  input wire logic [`CCMC_WORD_W-1:0] filt_mask [2],
  input wire logic data_filt_en,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [`CCMC_WORD_W:0] rx_data,
  input wire logic [`CCMC_IRQ_W-1:0] int_en,
  input wire logic [`CCMC_IRQ_W-1:0] int_clear,
  output logic [`CCMC_IRQ_W-1:0] int_flags,
  output logic int_n,
  output logic tx_line,
  input wire logic rx_line,
  input wire logic [1:0] clock_output_pin_div,
  input wire logic clock_output_pin_sof_en,
  output logic clock_out,
  output logic [7:0] err_count
);
  localparam int FW = `CCMC_WORD_W + 1;
  localparam logic [5:0] BIT_LAST = 6'(`CCMC_BIT_CYC - 1);
  localparam logic [7:0] OST_LAST = 8'(`CCMC_OST_CYC - 1);

  ccmc_pkg::ccmc_mode_t mode_q;
  ccmc_pkg::ccmc_rx_t rx_st_q;
  logic [5:0] bit_cnt_q;
  logic bit_tick;
  logic [7:0] ost_q;
  logic rx_prev_q;
  logic [2:0] rts_prev_q;
  logic [`CCMC_WORD_W-1:0] txbuf_q [3];
  logic [2:0] pend_q;
  logic tx_busy_q;
  logic [1:0] tx_sel_q;
  logic [FW-1:0] tx_sh_q;
  logic [4:0] tx_cnt_q;
  logic [`CCMC_WORD_W-1:0] rx_sh_q;
  logic [4:0] rx_cnt_q;
  logic [1:0] rxfull_q;
  logic [`CCMC_IRQ_W-1:0] flags_q;
  logic [2:0] clk_div_q;
  logic clk_q;
  logic sof_q;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic hit(input logic [`CCMC_WORD_W-1:0] w,
                               input logic [`CCMC_WORD_W-1:0] f,
                               input logic [`CCMC_WORD_W-1:0] m,
                               input logic use_data);
    logic [`CCMC_WORD_W-1:0] eff;
    eff = use_data ? m : {m[`CCMC_ID_MSB:`CCMC_ID_LSB], 8'h00};
    return ((w ^ f) & eff) == '0;
  endfunction : hit

  function automatic logic [2:0] code_of(input ccmc_pkg::ccmc_mode_t m);
    case (m)
      ccmc_pkg::CCMC_NORMAL: code_of = `CCMC_CODE_NORMAL;
      ccmc_pkg::CCMC_SLEEP: code_of = `CCMC_CODE_SLEEP;
      ccmc_pkg::CCMC_WAKING: code_of = `CCMC_CODE_SLEEP;
      ccmc_pkg::CCMC_LISTEN: code_of = `CCMC_CODE_LISTEN;
      ccmc_pkg::CCMC_LOOP: code_of = `CCMC_CODE_LOOP;
      default: code_of = `CCMC_CODE_CONFIG;
    endcase
  endfunction : code_of

  // ------------------------------------------------------------
  // Bit-rate enable
  // ------------------------------------------------------------
  assign bit_tick = (bit_cnt_q == BIT_LAST);

  always_ff @(posedge clk) begin
    if (!rst_n || mode_q == ccmc_pkg::CCMC_SLEEP) begin
      bit_cnt_q <= '0;
    end else if (bit_tick) begin
      bit_cnt_q <= '0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  // ------------------------------------------------------------
  // Mode control
  // ------------------------------------------------------------
  logic can_tx;
  logic tx_idle;
  logic req_valid;
  ccmc_pkg::ccmc_mode_t req_m;
  logic rx_fall;

  assign can_tx = (mode_q == ccmc_pkg::CCMC_NORMAL) ||
                  (mode_q == ccmc_pkg::CCMC_LOOP);
  // Pending work only blocks a change in modes that can transmit;
  // elsewhere it could never drain and the change would hang.
  assign tx_idle = !can_tx || (!tx_busy_q && pend_q == 3'h0);
  assign rx_fall = rx_prev_q && !rx_line;

  // Host access arrives as parallel ports; serial framing and its
  // clock modes and rate are handled in front of this block.
  always_comb begin
    req_valid = 1'b1;
    req_m = ccmc_pkg::CCMC_CONFIG;
    case (req_mode)
      `CCMC_CODE_NORMAL: req_m = ccmc_pkg::CCMC_NORMAL;
      `CCMC_CODE_SLEEP: req_m = ccmc_pkg::CCMC_SLEEP;
      `CCMC_CODE_LOOP: req_m = ccmc_pkg::CCMC_LOOP;
      `CCMC_CODE_LISTEN: req_m = ccmc_pkg::CCMC_LISTEN;
      `CCMC_CODE_CONFIG: req_m = ccmc_pkg::CCMC_CONFIG;
      default: req_valid = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= ccmc_pkg::CCMC_CONFIG;
      ost_q <= '0;
    end else begin
      case (mode_q)
        ccmc_pkg::CCMC_SLEEP: begin
          ost_q <= '0;
          if (rx_fall) begin
            mode_q <= ccmc_pkg::CCMC_WAKING;
          end else if (req_valid && req_m != ccmc_pkg::CCMC_SLEEP) begin
            mode_q <= req_m;
          end
        end
        ccmc_pkg::CCMC_WAKING: begin
          // Oscillator start-up: frames seen now are thrown away
          ost_q <= ost_q + 8'h01;
          if (ost_q == OST_LAST) begin
            mode_q <= ccmc_pkg::CCMC_LISTEN;
          end
        end
        default: begin
          if (req_valid && req_m != mode_q && tx_idle) begin
            mode_q <= req_m;
          end
        end
      endcase
    end
  end

  assign op_mode = code_of(mode_q);

  // ------------------------------------------------------------
  // Transmit buffers and request pins
  // ------------------------------------------------------------
  logic [2:0] pin_req;
  logic [1:0] win;
  logic win_ok;
  logic tx_start;
  logic tx_end;

  assign pin_req = rts_gpio_en ? 3'h0 : (rts_prev_q & ~rts_pin_n);

  always_comb begin
    win = 2'h0;
    win_ok = 1'b0;
    for (int i = 2; i >= 0; i--) begin
      if (pend_q[i] && (!win_ok || tx_prio[i] >= tx_prio[win])) begin
        win = 2'(i);
        win_ok = 1'b1;
      end
    end
  end

  assign tx_start = can_tx && !tx_busy_q && win_ok && bit_tick &&
                    rx_st_q == ccmc_pkg::CCMC_RX_IDLE;
  assign tx_end = tx_busy_q && bit_tick &&
                  tx_cnt_q == 5'(`CCMC_FRAME_BITS - 1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rts_prev_q <= 3'h7;
      rts_gpio_in <= 3'h7;
      rx_prev_q <= 1'b1;
    end else begin
      rts_prev_q <= rts_pin_n;
      rts_gpio_in <= rts_pin_n;
      rx_prev_q <= rx_line;
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (tx_load[i] && !pend_q[i]) begin
        txbuf_q[i] <= tx_load_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (tx_req[i] || pin_req[i]) begin
          pend_q[i] <= 1'b1;
        end else if (tx_end && tx_sel_q == 2'(i)) begin
          pend_q[i] <= 1'b0;
        end else if (tx_abort[i] &&
                     !(tx_busy_q && tx_sel_q == 2'(i))) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  assign tx_pending = pend_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_busy_q <= 1'b0;
      tx_sel_q <= 2'h0;
      tx_sh_q <= '1;
      tx_cnt_q <= '0;
    end else if (tx_start) begin
      tx_busy_q <= 1'b1;
      tx_sel_q <= win;
      tx_sh_q <= {1'b0, txbuf_q[win]};
      tx_cnt_q <= '0;
    end else if (tx_busy_q && bit_tick) begin
      tx_sh_q <= {tx_sh_q[FW-2:0], 1'b1};
      tx_cnt_q <= tx_cnt_q + 5'h01;
      if (tx_end) begin
        tx_busy_q <= 1'b0;
      end
    end
  end

  // Silent modes never drive the bus dominant
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_line <= 1'b1;
    end else if (mode_q == ccmc_pkg::CCMC_NORMAL && tx_busy_q) begin
      tx_line <= tx_sh_q[FW-1];
    end else begin
      tx_line <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Error counter
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || mode_q == ccmc_pkg::CCMC_CONFIG) begin
      err_count <= 8'h00;
    end else if (mode_q == ccmc_pkg::CCMC_LISTEN) begin
      err_count <= 8'h00;
    end else if (mode_q == ccmc_pkg::CCMC_NORMAL && tx_busy_q &&
                 bit_tick && rx_line != tx_line &&
                 err_count != 8'hFF) begin
      err_count <= err_count + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Receiver and acceptance
  // ------------------------------------------------------------
  ccmc_stream_if #(.W(FW)) acc_s ();
  ccmc_stream_if #(.W(FW)) out_s ();
  logic rx_done;
  logic frame_done;
  logic [`CCMC_WORD_W-1:0] frame;
  logic want;
  logic to1;
  logic accept;
  logic overflow;

  assign rx_done = rx_st_q == ccmc_pkg::CCMC_RX_SHIFT && bit_tick &&
                   rx_cnt_q == 5'(`CCMC_WORD_W - 1);

  // Back-pressure: no new frame is started while the FIFO is full
  always_ff @(posedge clk) begin
    if (!rst_n || can_tx && tx_busy_q ||
        mode_q == ccmc_pkg::CCMC_SLEEP ||
        mode_q == ccmc_pkg::CCMC_WAKING) begin
      rx_st_q <= ccmc_pkg::CCMC_RX_IDLE;
      rx_cnt_q <= '0;
    end else if (bit_tick) begin
      case (rx_st_q)
        ccmc_pkg::CCMC_RX_IDLE: begin
          rx_cnt_q <= '0;
          if (!rx_line && acc_s.ready &&
              mode_q != ccmc_pkg::CCMC_LOOP) begin
            rx_st_q <= ccmc_pkg::CCMC_RX_SHIFT;
          end
        end
        default: begin
          rx_sh_q <= {rx_sh_q[`CCMC_WORD_W-2:0], rx_line};
          rx_cnt_q <= rx_cnt_q + 5'h01;
          if (rx_done) begin
            rx_st_q <= ccmc_pkg::CCMC_RX_IDLE;
          end
        end
      endcase
    end
  end

  // Loopback hands the outgoing word straight to acceptance
  assign frame_done = (mode_q == ccmc_pkg::CCMC_LOOP) ? tx_end : rx_done;
  assign frame = (mode_q == ccmc_pkg::CCMC_LOOP) ? txbuf_q[tx_sel_q] :
                 {rx_sh_q[`CCMC_WORD_W-2:0], rx_line};

  always_comb begin
    want = 1'b0;
    to1 = 1'b0;
    case (mode_q)
      ccmc_pkg::CCMC_LISTEN: begin
        want = 1'b1;
        to1 = rxfull_q[0];
      end
      ccmc_pkg::CCMC_NORMAL, ccmc_pkg::CCMC_LOOP: begin
        if (hit(frame, filt_val[0], filt_mask[0], data_filt_en) ||
            hit(frame, filt_val[1], filt_mask[0], data_filt_en)) begin
          want = 1'b1;
        end else begin
          for (int i = 2; i < 6; i++) begin
            if (hit(frame, filt_val[i], filt_mask[1], data_filt_en)) begin
              want = 1'b1;
              to1 = 1'b1;
            end
          end
        end
      end
      default: want = 1'b0;
    endcase
  end

  assign accept = frame_done && want && !rxfull_q[to1] && acc_s.ready;
  assign overflow = frame_done && want && !accept;
  assign acc_s.valid = accept;
  assign acc_s.data = {to1, frame};

  ccmc_fifo #(.W(FW), .DEPTH(`CCMC_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .wr(acc_s),
    .rd(out_s)
  );

  assign rx_valid = out_s.valid;
  assign rx_data = out_s.data;
  assign out_s.ready = rx_ready;

  // ------------------------------------------------------------
  // Status flags and interrupt; a new event wins over a clear
  // ------------------------------------------------------------
  logic [`CCMC_IRQ_W-1:0] ev;

  always_comb begin
    ev = '0;
    ev[`CCMC_IRQ_RX0] = accept && !to1;
    ev[`CCMC_IRQ_RX1] = accept && to1;
    ev[`CCMC_IRQ_TX0 + 32'(tx_sel_q)] = tx_end;
    ev[`CCMC_IRQ_WAKE] = mode_q == ccmc_pkg::CCMC_SLEEP && rx_fall;
    ev[`CCMC_IRQ_OVF] = overflow;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= ev | (flags_q & ~int_clear);
    end
  end

  assign rxfull_q = flags_q[`CCMC_IRQ_RX1:`CCMC_IRQ_RX0];
  assign int_flags = flags_q;
  assign int_n = ~|(flags_q & int_en);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_full_pin_n <= 2'h3;
    end else if (rxf_gpio_en) begin
      rx_full_pin_n <= rxf_gpio_out;
    end else begin
      rx_full_pin_n <= ~rxfull_q;
    end
  end

  // ------------------------------------------------------------
  // Clock output / start-of-frame marker
  // ------------------------------------------------------------
  logic [2:0] half_last;
  assign half_last = 3'((4'h1 << clock_output_pin_div) - 4'h1);

  always_ff @(posedge clk) begin
    if (!rst_n || mode_q == ccmc_pkg::CCMC_SLEEP) begin
      clk_div_q <= '0;
      clk_q <= 1'b0; // Oscillator stopped in sleep
    end else if (clk_div_q >= half_last) begin
      clk_div_q <= '0;
      clk_q <= ~clk_q;
    end else begin
      clk_div_q <= clk_div_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sof_q <= 1'b0;
    end else if (tx_start ||
                 (bit_tick && rx_st_q == ccmc_pkg::CCMC_RX_IDLE &&
                  !rx_line && !tx_busy_q)) begin
      sof_q <= 1'b1;
    end else if (bit_tick) begin
      sof_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clock_out <= 1'b0;
    end else begin
      clock_out <= clock_output_pin_sof_en ? sof_q : clk_q;
    end
  end
endmodule : ccmc_top

// File: shared/ccmc_params.svh
// Behaviour
// - Five operating modes: configuration, normal, sleep, listen-only, loopback.
// - Host writes a three-bit requested-mode field; device treats it as request.
// - Mode change waits until all pending transmissions have finished; the code waits only when leaving normal or loopback mode.
// - Active mode reported in three-bit status field; host confirms by reading.
// - One interrupt output stays asserted until host clears the condition.
// - Three transmit buffers, prioritised, each pending request abortable; the code ignores an abort of the buffer being transmitted.
// - Per-buffer request inputs and per-receive-buffer full outputs, also host reachable.
// - Full outputs and request inputs can serve as general-purpose pins.
// - Six filters, two masks; filtering may extend to first data byte.
// - Serial host port works in clock modes 0,0 and 1,1.
// - Serial host clock at most 10 MHz.
// - Protocol engine runs at bus bit rates up to 1 Mb/s.
// - Clock output derived from oscillator, alternatively signals start of frame.
// - Reset enters configuration mode; entering configuration clears error counters.
// - Listen-only: transmit nothing, receive all frames, error counters reset, inactive.
// - Loopback: transmit buffers feed receive buffers, transmit line recessive.
// - Wake from sleep discards wake frame and start-up frames, resumes listen-only; the code drops only wake-frame bits seen before start-up ends.
`ifndef CCMC_PARAMS_SVH
`define CCMC_PARAMS_SVH

// Requested-mode and status codes
`define CCMC_CODE_NORMAL 3'h0
`define CCMC_CODE_SLEEP 3'h1
`define CCMC_CODE_LOOP 3'h2
`define CCMC_CODE_LISTEN 3'h3
`define CCMC_CODE_CONFIG 3'h4

// Timing
`define CCMC_CLK_NS 20
`define CCMC_BIT_NS 1000
`define CCMC_BIT_CYC (`CCMC_BIT_NS / `CCMC_CLK_NS)
`define CCMC_OST_CYC 128

// Frame layout: start bit plus identifier byte plus data byte
`define CCMC_WORD_W 16
`define CCMC_FRAME_BITS 17
`define CCMC_ID_MSB 15
`define CCMC_ID_LSB 8
`define CCMC_FIFO_DEPTH 16

// Interrupt flag positions
`define CCMC_IRQ_RX0 0
`define CCMC_IRQ_RX1 1
`define CCMC_IRQ_TX0 2
`define CCMC_IRQ_WAKE 5
`define CCMC_IRQ_OVF 6
`define CCMC_IRQ_W 7

`endif

// File: shared/ccmc_pkg.sv
package ccmc_pkg;
  typedef enum logic [2:0] {
    CCMC_CONFIG,
    CCMC_NORMAL,
    CCMC_SLEEP,
    CCMC_WAKING,
    CCMC_LISTEN,
    CCMC_LOOP
  } ccmc_mode_t;

  typedef enum logic {
    CCMC_RX_IDLE,
    CCMC_RX_SHIFT
  } ccmc_rx_t;
endpackage : ccmc_pkg

// File: shared/ccmc_stream_if.sv
`timescale 1ns/1ps
interface ccmc_stream_if #(
  parameter int W = 17
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ccmc_stream_if

// File: logic/ccmc_fifo.sv
`timescale 1ns/1ps
module ccmc_fifo #(
  parameter int W = 17,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  ccmc_stream_if.snk wr,
  ccmc_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data = mem_q[rptr_q];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wptr_q] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + AW'(1);
      end
      if (pop) begin
        rptr_q <= rptr_q + AW'(1);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + (AW+1)'(1);
      end else if (pop && !push) begin
        cnt_q <= cnt_q - (AW+1)'(1);
      end
    end
  end
endmodule : ccmc_fifo

// File: test/ccmc_bus_node.sv
`timescale 1ns/1ps
`include "ccmc_params.svh"
module ccmc_bus_node (
  input wire logic clk,
  input wire logic tx_line,
  input wire logic go,
  input wire logic [15:0] word,
  output logic rx_line,
  output logic busy,
  output logic [15:0] got_word
);
  logic drive = 1'b1;
  // Wired-AND bus: a released node leaves the pull-up level
  assign rx_line = drive & tx_line;
  initial begin
    busy = 1'b0;
    got_word = 16'h0000;
  end
  // ----------------------------------------
  // Sender: start bit then 16 bits MSB first
  // ----------------------------------------
  always begin : sender
    @(posedge clk iff go);
    #1 busy = 1'b1;
    for (int i = 16; i >= 0; i--) begin
      drive = (i == 16) ? 1'b0 : word[i];
      repeat (`CCMC_BIT_CYC) @(posedge clk);
      #1;
    end
    drive = 1'b1;
    // Gap so the receiver is idle before the next frame
    repeat (4 * `CCMC_BIT_CYC) @(posedge clk);
    #1 busy = 1'b0;
  end
  // ----------------------------------------
  // Listener: samples each bit at its middle
  // ----------------------------------------
  always begin : listener
    @(negedge tx_line);
    repeat (`CCMC_BIT_CYC / 2) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      repeat (`CCMC_BIT_CYC) @(posedge clk);
      got_word[i] = tx_line;
    end
  end
endmodule : ccmc_bus_node

// File: test/ccmc_top_assertions.sv
`timescale 1ns/1ps
`include "ccmc_params.svh"
module ccmc_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] req_mode,
  input wire logic [2:0] op_mode,
  input wire logic [2:0] tx_req,
  input wire logic [2:0] tx_pending,
  input wire logic [2:0] rts_pin_n,
  input wire logic rts_gpio_en,
  input wire logic [2:0] rts_gpio_in,
  input wire logic rxf_gpio_en,
  input wire logic [1:0] rxf_gpio_out,
  input wire logic [1:0] rx_full_pin_n,
  input wire logic [`CCMC_IRQ_W-1:0] int_en,
  input wire logic [`CCMC_IRQ_W-1:0] int_clear,
  input wire logic [`CCMC_IRQ_W-1:0] int_flags,
  input wire logic int_n,
  input wire logic tx_line,
  input wire logic [7:0] err_count
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_reset_mode: assert property ($rose(rst_n) |->
    op_mode == `CCMC_CODE_CONFIG && err_count == 8'h00 && int_n)
    else $error("mode after reset");
  chk_mode_codes: assert property (op_mode <= 3'h4)
    else $error("mode code out of range");
  chk_mode_defer: assert property (op_mode == `CCMC_CODE_NORMAL &&
    tx_pending != 3'h0 && req_mode != op_mode |=> op_mode == $past(op_mode))
    else $error("mode changed with transfers pending");
  chk_defer_release: assert property ($fell(|tx_pending) &&
    op_mode == `CCMC_CODE_NORMAL && req_mode == `CCMC_CODE_CONFIG
    |-> ##[1:3] op_mode == `CCMC_CODE_CONFIG)
    else $error("deferred mode not taken");
  chk_mode_take: assert property (req_mode <= 3'h4 && req_mode != op_mode &&
    (op_mode == `CCMC_CODE_CONFIG || op_mode == `CCMC_CODE_LISTEN)
    |=> op_mode == $past(req_mode))
    else $error("requested mode not taken");
  chk_bad_code: assert property (req_mode > 3'h4 &&
    op_mode != `CCMC_CODE_SLEEP |=> $stable(op_mode))
    else $error("mode changed on unknown code");
  chk_flag_sticky: assert property (1'b1 |=>
    ($past(int_flags & ~int_clear) & ~int_flags) == 7'h00)
    else $error("flag dropped without clear");
  chk_int_level: assert property (int_n == !(|(int_flags & int_en)))
    else $error("interrupt level");
  chk_rxf_gpio: assert property (rxf_gpio_en |=>
    rx_full_pin_n == $past(rxf_gpio_out))
    else $error("full pins not general purpose");
  chk_rts_gpio: assert property (rts_gpio_en && tx_req == 3'h0 &&
    tx_pending == 3'h0 |=> tx_pending == 3'h0 &&
    rts_gpio_in == $past(rts_pin_n))
    else $error("request pins not general purpose");
  chk_silent_tx: assert property ((op_mode == `CCMC_CODE_LOOP ||
    op_mode == `CCMC_CODE_LISTEN) && $stable(op_mode) |-> tx_line)
    else $error("transmit line not recessive");
  chk_err_zero: assert property ((op_mode == `CCMC_CODE_LISTEN ||
    op_mode == `CCMC_CODE_CONFIG) && $stable(op_mode) |-> err_count == 8'h00)
    else $error("error count not cleared");
endmodule : ccmc_checker
bind ccmc_top ccmc_checker u_chk (.clk(clk), .rst_n(rst_n),
  .req_mode(req_mode), .op_mode(op_mode), .tx_req(tx_req),
  .tx_pending(tx_pending), .rts_pin_n(rts_pin_n), .rts_gpio_en(rts_gpio_en),
  .rts_gpio_in(rts_gpio_in), .rxf_gpio_en(rxf_gpio_en),
  .rxf_gpio_out(rxf_gpio_out), .rx_full_pin_n(rx_full_pin_n),
  .int_en(int_en), .int_clear(int_clear), .int_flags(int_flags),
  .int_n(int_n), .tx_line(tx_line), .err_count(err_count));

// File: test/ccmc_top_bench.sv
`timescale 1ns/1ps
`include "ccmc_params.svh"
module ccmc_top_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] req_mode, op_mode, tx_load, tx_req, tx_abort, tx_pending;
  logic [2:0] rts_pin_n, rts_gpio_in;
  logic [1:0] tx_prio [3];
  logic [15:0] tx_load_data, node_word, got_word, w [3];
  logic [15:0] filt_val [6];
  logic [15:0] filt_mask [2];
  logic [1:0] rx_full_pin_n, rxf_gpio_out, clock_output_pin_div;
  logic [6:0] int_en, int_clear, int_flags;
  logic [16:0] rx_data;
  logic [16:0] exp_q [$];
  logic [7:0] err_count;
  logic rts_gpio_en, rxf_gpio_en, rx_valid, rx_ready, int_n, tx_line;
  logic rx_line, clock_out, node_go, node_busy, hold_rx, prev, dfe, sof;
  logic [31:0] seed = 32'h29423250;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  ccmc_top DUT (.clk(clk), .rst_n(rst_n), .req_mode(req_mode),
    .op_mode(op_mode), .tx_load(tx_load), .tx_load_data(tx_load_data),
    .tx_req(tx_req), .tx_abort(tx_abort), .tx_prio(tx_prio),
    .tx_pending(tx_pending), .rts_pin_n(rts_pin_n),
    .rts_gpio_en(rts_gpio_en), .rts_gpio_in(rts_gpio_in),
    .rx_full_pin_n(rx_full_pin_n), .rxf_gpio_en(rxf_gpio_en),
    .rxf_gpio_out(rxf_gpio_out), .filt_val(filt_val),
    .filt_mask(filt_mask), .data_filt_en(dfe), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .int_en(int_en),
    .int_clear(int_clear), .int_flags(int_flags), .int_n(int_n),
    .tx_line(tx_line), .rx_line(rx_line), .clock_output_pin_div(clock_output_pin_div),
    .clock_output_pin_sof_en(sof), .clock_out(clock_out), .err_count(err_count));
  ccmc_bus_node node (.clk(clk), .tx_line(tx_line), .go(node_go),
    .word(node_word), .rx_line(rx_line), .busy(node_busy),
    .got_word(got_word));
  initial begin
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : check
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic wait_idle(input bit q);
    n = 0;
    while (tx_pending !== 3'h0 || node_busy !== 1'b0 ||
           (q && exp_q.size() != 0)) begin
      tick(1);
      n++;
      if (n > 30000) begin
        mismatches++;
        test_done();
      end
    end
  endtask : wait_idle
  task automatic load(input int b, input logic [15:0] d);
    tx_load = 3'h1 << b;
    tx_load_data = d;
    tick(1);
    tx_load = 3'h0;
    tick(1);
  endtask : load
  task automatic send(input logic [15:0] d);
    node_word = d;
    node_go = 1'b1;
    tick(1);
    node_go = 1'b0;
    tick(2);
  endtask : send
  // ----------------------------------------
  // Host side of the receive stream
  // ----------------------------------------
  always @(posedge clk) begin
    #1;
    cyc++;
    rx_ready = !hold_rx && (cyc % 3 != 0);
  end
  // Ready is stable from just after one edge to the next
  always @(negedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (exp_q.size() == 0) check(rx_data, 32'hFFFFFFFF);
      else check(rx_data, exp_q.pop_front());
    end
  end
  initial begin
    {req_mode, tx_load, tx_req, tx_abort} = {3'h4, 9'h000};
    {rts_pin_n, rts_gpio_en, rxf_gpio_en, rxf_gpio_out} = 7'h70;
    {tx_load_data, node_word, node_go, hold_rx, dfe, sof} = 36'h0;
    {int_en, int_clear, clock_output_pin_div} = {7'h00, 7'h03, 2'h1};
    tx_prio = '{2'h3, 2'h0, 2'h3};
    filt_val = '{default: 16'h2200};
    filt_mask = '{16'h0000, 16'hFF00};
    tick(10);
    rst_n = 1'b1;
    check(op_mode, `CCMC_CODE_CONFIG);
    check({int_n, tx_line, rx_full_pin_n, rts_gpio_in, clock_out, err_count},
      16'hFE00);
    // Codes 7..5 are refused, then every mode is entered
    for (int c = 7; c >= 0; c--) begin
      req_mode = c[2:0];
      tick(3);
      check(op_mode, (c > 4) ? `CCMC_CODE_CONFIG : c);
    end
    $display("test modes done");
    req_mode = `CCMC_CODE_CONFIG;
    tick(3);
    for (int b = 0; b < 3; b++) begin
      w[b] = rnd();
      load(b, w[b]);
    end
    tx_req = 3'h7;
    tick(2);
    tx_req = 3'h0;
    check(tx_pending, 3'h7);
    tx_abort = 3'h2;
    tick(2);
    tx_abort = 3'h0;
    check(tx_pending, 3'h5);
    w[1] = rnd();
    load(1, w[1]);
    tx_req = 3'h2;
    tick(1);
    tx_req = 3'h0;
    // Higher priority first, tie goes to the lower index
    exp_q = '{{1'b0, w[0]}, {1'b0, w[2]}, {1'b0, w[1]}};
    int_en = 7'h1C;
    req_mode = `CCMC_CODE_LOOP;
    wait_idle(1);
    check({int_flags[4:2], int_n}, 4'hE);
    int_clear = 7'h1F;
    tick(1);
    int_clear = 7'h03;
    tick(1);
    check(int_n, 1'b1);
    $display("test loopback done");
    req_mode = `CCMC_CODE_NORMAL;
    tick(3);
    w[0] = rnd();
    load(1, w[0]);
    rts_pin_n = 3'h5;
    tick(1);
    rts_pin_n = 3'h7;
    tick(2);
    check(tx_pending, 3'h2);
    req_mode = `CCMC_CODE_CONFIG;
    tick(100);
    check(op_mode, `CCMC_CODE_NORMAL);
    wait_idle(1);
    tick(2);
    check({op_mode, got_word}, {`CCMC_CODE_CONFIG, w[0]});
    $display("test defer done");
    filt_mask[0] = 16'hFFFF;
    filt_val[0] = 16'h1100;
    filt_val[1] = 16'h1100;
    req_mode = `CCMC_CODE_NORMAL;
    tick(3);
    for (int f = 1; f <= 4; f++) begin
      dfe = f > 3;
      w[0] = {(f > 3) ? 8'h11 : {4'(f), 4'(f)}, 8'(rnd()) | 8'h01};
      if (f < 3) exp_q.push_back({f == 2, w[0]});
      send(w[0]);
      wait_idle(1);
    end
    // Listen takes all frames; host stalls until the buffer refuses
    req_mode = `CCMC_CODE_LISTEN;
    tick(3);
    hold_rx = 1'b1;
    for (int f = 0; f < 17; f++) begin
      w[0] = rnd();
      if (f < `CCMC_FIFO_DEPTH) exp_q.push_back({1'b0, w[0]});
      send(w[0]);
      wait_idle(0);
    end
    hold_rx = 1'b0;
    wait_idle(1);
    $display("test receive done");
    req_mode = `CCMC_CODE_SLEEP;
    tick(3);
    req_mode = 3'h5;
    send(16'hFFFF);
    tick(60);
    check({op_mode, int_flags[5]}, {`CCMC_CODE_SLEEP, 1'b1});
    wait_idle(1);
    check(op_mode, `CCMC_CODE_LISTEN);
    $display("test wake done");
    req_mode = `CCMC_CODE_CONFIG;
    {rts_gpio_en, rxf_gpio_en, rxf_gpio_out} = {2'h3, 2'(rnd())};
    rts_pin_n = 3'h0;
    tick(3);
    check({tx_pending, rts_gpio_in}, 6'h00);
    check(rx_full_pin_n, rxf_gpio_out);
    rts_pin_n = 3'h7;
    n = 0;
    prev = clock_out;
    for (int k = 0; k < 32; k++) begin
      tick(1);
      if (clock_out !== prev) n++;
      prev = clock_out;
    end
    check(n, 16);
    sof = 1'b1;
    send(16'h0F0F);
    tick(49);
    check(clock_out, 1'b1);
    wait_idle(1);
    $display("test pins done");
    test_done();
  end
endmodule : ccmc_top_bench
